/* watchdog_defines.svh */
`ifndef WATCHDOG_DEFINES_SVH
`define WATCHDOG_DEFINES_SVH

// Register byte offsets
`define OFS_CTRL        8'h00
`define OFS_TIMEOUT     8'h04
`define OFS_GRACE       8'h08
`define OFS_DELAY       8'h0c
`define OFS_CAP_SCALE   8'h10
`define OFS_STATUS      8'h14

// Control field positions
`define CTRL_CAP_TIMED  0
`define CTRL_SINGLE_OUT 1
`define CTRL_HAS_EN_PIN 2
`define CTRL_DELAY_CAP  3
`define CTRL_WIDTH      4

// Reset values
`define RST_CTRL        4'h2
`define RST_TIMEOUT     32'h0000_2710
`define RST_GRACE       32'h0000_0000
`define RST_DELAY       32'h0000_2710
`define RST_CAP_SCALE   16'h0010

// Timing figures, in microseconds, and the clock and tick periods in ns
`define CLK_PERIOD_NS   10
`define TICK_NS         1000
`define POWER_UP_US     500
`define DELAY_OPEN_US   2000
`define GRACE_CAP_US    10000000
`define TIMEOUT_MIN_US  1000
`define TIMEOUT_MAX_US  100000000
`define DISCHARGE_US    20
`define CAP_LIMIT_US    65535

`endif

/* watchdog_pkg.sv */
package watchdog_pkg;

  typedef enum logic [1:0] {SV_POWER, SV_LOW, SV_HOLD, SV_OK} sv_state_type;

  typedef enum logic [2:0] {
    WD_IDLE, WD_MEAS_CHG, WD_MEAS_DIS, WD_GRACE, WD_RUN, WD_FAULT, WD_OFF
  } wd_state_type;

endpackage

/* supervised_timeout_watchdog.sv */
// Our own choices: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`include "watchdog_defines.svh"
// Function
// - Power-up holds reset startup plus assert delay
// - Open delay capacitor sets assert delay to 2ms
// - Single output ANDs supervisor and fault
// - Undervoltage asserts reset; release after recovery delay
// - Supervisor reset disables all watchdog activity
// - Watchdog active after release while enabled
// - Each valid kick edge restarts timeout
// - Missed kick asserts output for assert delay
// - Capacitor measured once per reset event
// - Timeout scales with measured capacitance
// - Fixed timeout limited to 1ms..100s
// - Enable pin high runs, low disables
// - Select code 01 disables watchdog
// - Bad timeout capacitor disables, overriding others
// - Capacitor re-evaluated only after recovery
// - Disable aborts frame, fault held deasserted
// - Enabling starts timeout frame immediately
// - Enabling never starts a grace frame
// - Grace after power-up, reset or fault
// - Kick, select change, enable toggle end grace
// - Grace expiry raises watchdog error
// - Capacitor variants: grace zero or 10s
// - Reset clears fault and restarts grace
// - Timeout-altering select change restarts frame
module supervised_timeout_watchdog
  import watchdog_pkg::*;
#(
  parameter int TICK_CYCLES      = (`TICK_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
  parameter int POWER_UP_TICKS   = `POWER_UP_US,
  parameter int DELAY_OPEN_TICKS = `DELAY_OPEN_US,
  parameter int GRACE_CAP_TICKS  = `GRACE_CAP_US,
  parameter int TIMEOUT_MIN      = `TIMEOUT_MIN_US,
  parameter int TIMEOUT_MAX      = `TIMEOUT_MAX_US,
  parameter int DISCHARGE_TICKS  = `DISCHARGE_US,
  parameter int CAP_LIMIT        = `CAP_LIMIT_US
) (
  input  wire logic        hclk,               // System clock
  input  wire logic        hresetn,            // Async reset, active low
  input  wire logic        hsel,               // Slave select
  input  wire logic [7:0]  haddr,              // Byte address
  input  wire logic [1:0]  htrans,             // Transfer type
  input  wire logic        hwrite,             // Write not read
  input  wire logic [2:0]  hsize,              // Transfer size
  input  wire logic [31:0] hwdata,             // Write data
  input  wire logic        hready,             // Bus ready
  output logic      [31:0] hrdata,             // Read data
  output logic             hreadyout,          // Slave ready
  output logic             hresp,              // Always OKAY
  input  wire logic        supply_ok_in,       // Supply above threshold (hysteresis)
  input  wire logic        por_ok_in,          // Supply above power-on level
  input  wire logic        watchdog_kick_in,   // Kick from host
  input  wire logic        watchdog_enable_pin,// Enable pin
  input  wire logic        scale_select_low,   // Select bit 0
  input  wire logic        scale_select_high,  // Select bit 1
  input  wire logic        cap_sense_in,       // Timeout capacitor charged
  input  wire logic        delay_cap_open_in,  // Delay capacitor pin open
  output logic             cap_charge_out,     // Charge timeout capacitor
  output logic             cap_discharge_out,  // Discharge timeout capacitor
  output logic             reset_out_n,        // System reset, active low
  output logic             watchdog_fault_out_n// Separate fault, active low
);

  localparam int NPIN = 8;

  // Three-stage synchronisers, stable value once stages two and three agree
  logic [NPIN-1:0] s1_q, s2_q, s3_q, pin_q;
  wire  [NPIN-1:0] pins = {delay_cap_open_in, cap_sense_in, scale_select_high,
                           scale_select_low, watchdog_enable_pin, watchdog_kick_in,
                           por_ok_in, supply_ok_in};
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1_q  <= '0;
      s2_q  <= '0;
      s3_q  <= '0;
      pin_q <= '0;
    end else begin
      s1_q <= pins;
      s2_q <= s1_q;
      s3_q <= s2_q;
      for (int i = 0; i < NPIN; i++) begin
        if (s2_q[i] == s3_q[i]) begin
          pin_q[i] <= s3_q[i];
        end
      end
    end
  end

  logic       supply_ok, por_ok, kick_lvl, en_lvl, sense, dly_open;
  logic [1:0] sel;
  assign supply_ok = pin_q[0];
  assign por_ok    = pin_q[1];
  assign kick_lvl  = pin_q[2];
  assign en_lvl    = pin_q[3];
  assign sel       = pin_q[5:4];
  assign sense     = pin_q[6];
  assign dly_open  = pin_q[7];

  // Registers
  logic [`CTRL_WIDTH-1:0] ctrl_q;
  logic [31:0]            timeout_q, grace_q, delay_q;
  logic [15:0]            scale_q;
  logic                   cap_timed, single_out, has_en, delay_cap;
  assign cap_timed  = ctrl_q[`CTRL_CAP_TIMED];
  assign single_out = ctrl_q[`CTRL_SINGLE_OUT];
  assign has_en     = ctrl_q[`CTRL_HAS_EN_PIN];
  assign delay_cap  = ctrl_q[`CTRL_DELAY_CAP];

  // Free-running timebase
  logic [15:0] tick_cnt_q;
  logic        tick;
  assign tick = (tick_cnt_q == 16'(TICK_CYCLES - 1));
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tick_cnt_q <= '0;
    end else begin
      tick_cnt_q <= tick ? '0 : tick_cnt_q + 16'h0001;
    end
  end

  // Edge and change detection on stable pin levels
  logic       kick_prev_q, en_prev_q;
  logic [1:0] sel_prev_q, eff_prev_q, eff_sel;
  logic       kick_fall, en_toggle, sel_change, sel_alter;
  assign eff_sel    = (has_en && sel == 2'h1) ? 2'h0 : sel;
  assign kick_fall  = kick_prev_q && !kick_lvl;
  assign en_toggle  = has_en && (en_prev_q != en_lvl);
  assign sel_change = sel_prev_q != sel;
  assign sel_alter  = eff_prev_q != eff_sel;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      kick_prev_q <= 1'b0;
      en_prev_q   <= 1'b0;
      sel_prev_q  <= 2'h0;
      eff_prev_q  <= 2'h0;
    end else begin
      kick_prev_q <= kick_lvl;
      en_prev_q   <= en_lvl;
      sel_prev_q  <= sel;
      eff_prev_q  <= eff_sel;
    end
  end

  // Clamp a fixed timeout into the offered range
  function automatic logic [31:0] clamp_timeout(input logic [31:0] v);
    if (v < 32'(TIMEOUT_MIN)) begin
      return 32'(TIMEOUT_MIN);
    end else if (v > 32'(TIMEOUT_MAX)) begin
      return 32'(TIMEOUT_MAX);
    end
    return v;
  endfunction

  // Derived periods in ticks
  logic [15:0] meas_q;
  logic        cap_bad_q, need_meas_q;
  logic [31:0] assert_ticks, timeout_ticks, grace_ticks;
  assign assert_ticks  = (delay_cap && dly_open) ? 32'(DELAY_OPEN_TICKS)
                                                 : delay_q;
  assign timeout_ticks = cap_timed ? {16'h0000, meas_q} * {16'h0000, scale_q}
                                   : clamp_timeout(timeout_q);
  assign grace_ticks   = !cap_timed ? grace_q :
                         (grace_q != 32'h0) ? 32'(GRACE_CAP_TICKS) : 32'h0;

  // Watchdog enable: capacitor disable first, then pin or select code
  logic wd_enabled;
  assign wd_enabled = !(cap_timed && cap_bad_q)
                      && (has_en ? en_lvl
                                 : (sel != 2'h1));

  // Supervisor state machine
  sv_state_type sv_q;
  logic [31:0]  sv_cnt_q;
  logic         sup_ok;
  assign sup_ok = (sv_q == SV_OK);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sv_q     <= SV_POWER;
      sv_cnt_q <= '0;
    end else if (!por_ok) begin
      sv_q <= SV_POWER;
    end else begin
      unique case (sv_q)
        SV_POWER: begin
          if (supply_ok) begin
            sv_q     <= SV_HOLD;
            sv_cnt_q <= 32'(POWER_UP_TICKS) + assert_ticks;
          end
        end
        SV_LOW: begin
          if (supply_ok) begin
            sv_q     <= SV_HOLD;
            sv_cnt_q <= assert_ticks;
          end
        end
        SV_HOLD: begin
          if (!supply_ok) begin
            sv_q <= SV_LOW;
          end else if (sv_cnt_q == 32'h0) begin
            sv_q <= SV_OK;
          end else if (tick) begin
            sv_cnt_q <= sv_cnt_q - 32'h1;
          end
        end
        SV_OK: begin
          if (!supply_ok) begin
            sv_q <= SV_LOW;
          end
        end
      endcase
    end
  end

  // Watchdog state machine
  wd_state_type wd_q;
  logic [31:0]  wd_cnt_q;
  logic         cnt_done;
  assign cnt_done = (wd_cnt_q == 32'h0);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wd_q        <= WD_IDLE;
      wd_cnt_q    <= '0;
      meas_q      <= '0;
      cap_bad_q   <= 1'b0;
      need_meas_q <= 1'b1;
    end else if (!sup_ok) begin
      wd_q        <= WD_IDLE;
      need_meas_q <= 1'b1;
    end else begin
      if (tick && !cnt_done) begin
        wd_cnt_q <= wd_cnt_q - 32'h1;
      end
      unique case (wd_q)
        WD_IDLE: begin
          if (cap_timed && need_meas_q) begin
            wd_q   <= WD_MEAS_CHG;
            meas_q <= '0;
          end else if (!wd_enabled) begin
            wd_q <= WD_OFF;
          end else if (grace_ticks == 32'h0) begin
            wd_q     <= WD_RUN;
            wd_cnt_q <= timeout_ticks;
          end else begin
            wd_q     <= WD_GRACE;
            wd_cnt_q <= grace_ticks;
          end
        end
        WD_MEAS_CHG: begin
          if (sense || meas_q == 16'(CAP_LIMIT)) begin
            cap_bad_q <= !sense;
            wd_q      <= WD_MEAS_DIS;
            wd_cnt_q  <= 32'(DISCHARGE_TICKS);
          end else if (tick) begin
            meas_q <= meas_q + 16'h0001;
          end
        end
        WD_MEAS_DIS: begin
          if (cnt_done) begin
            need_meas_q <= 1'b0;
            wd_q        <= WD_IDLE;
          end
        end
        WD_GRACE: begin
          if (!wd_enabled) begin
            wd_q <= WD_OFF;
          end else if (kick_fall || sel_change || en_toggle) begin
            wd_q     <= WD_RUN;
            wd_cnt_q <= timeout_ticks;
          end else if (cnt_done) begin
            wd_q     <= WD_FAULT;
            wd_cnt_q <= assert_ticks;
          end
        end
        WD_RUN: begin
          if (!wd_enabled) begin
            wd_q <= WD_OFF;
          end else if (kick_fall || sel_alter) begin
            wd_cnt_q <= timeout_ticks;
          end else if (cnt_done) begin
            wd_q     <= WD_FAULT;
            wd_cnt_q <= assert_ticks;
          end
        end
        WD_FAULT: begin
          if (!wd_enabled) begin
            wd_q <= WD_OFF;
          end else if (cnt_done) begin
            wd_q     <= (grace_ticks == 32'h0) ? WD_RUN : WD_GRACE;
            wd_cnt_q <= (grace_ticks == 32'h0) ? timeout_ticks : grace_ticks;
          end
        end
        WD_OFF: begin
          if (wd_enabled) begin
            wd_q     <= WD_RUN;
            wd_cnt_q <= timeout_ticks;
          end
        end
      endcase
    end
  end

  // Output pins; fault drops whenever the supervisor resets
  logic fault;
  assign fault = sup_ok && (wd_q == WD_FAULT);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      reset_out_n          <= 1'b0;
      watchdog_fault_out_n <= 1'b1;
      cap_charge_out       <= 1'b0;
      cap_discharge_out    <= 1'b0;
    end else begin
      reset_out_n          <= sup_ok && !(single_out && fault);
      watchdog_fault_out_n <= single_out || !fault;
      cap_charge_out       <= sup_ok && (wd_q == WD_MEAS_CHG);
      cap_discharge_out    <= sup_ok && (wd_q == WD_MEAS_DIS);
    end
  end

  // Bus address phase capture
  logic       wr_pend_q;
  logic [7:0] wr_addr_q;
  logic       take;
  assign take = hsel && htrans[1] && hready;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= '0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      wr_pend_q <= take && hwrite;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      if (take) begin
        wr_addr_q <= haddr;
      end
    end
  end

  // Register writes in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q    <= `RST_CTRL;
      timeout_q <= `RST_TIMEOUT;
      grace_q   <= `RST_GRACE;
      delay_q   <= `RST_DELAY;
      scale_q   <= `RST_CAP_SCALE;
    end else if (wr_pend_q) begin
      unique case (wr_addr_q)
        `OFS_CTRL:      ctrl_q    <= hwdata[`CTRL_WIDTH-1:0];
        `OFS_TIMEOUT:   timeout_q <= hwdata;
        `OFS_GRACE:     grace_q   <= hwdata;
        `OFS_DELAY:     delay_q   <= hwdata;
        `OFS_CAP_SCALE: scale_q   <= hwdata[15:0];
        default: ;
      endcase
    end
  end

  // Read data prepared at the address phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= '0;
    end else if (take && !hwrite) begin
      unique case (haddr)
        `OFS_CTRL:      hrdata <= {28'h0, ctrl_q};
        `OFS_TIMEOUT:   hrdata <= timeout_q;
        `OFS_GRACE:     hrdata <= grace_q;
        `OFS_DELAY:     hrdata <= delay_q;
        `OFS_CAP_SCALE: hrdata <= {16'h0, scale_q};
        `OFS_STATUS:    hrdata <= {meas_q, 6'h0, wd_enabled, cap_bad_q,
                                   1'b0, wd_q, sv_q, !reset_out_n, !watchdog_fault_out_n};
        default:        hrdata <= '0;
      endcase
    end
  end

endmodule

/* watchdog_props.sv */
`timescale 1ns/1ps
module watchdog_props (
  input wire logic hclk,                 // Clock
  input wire logic hresetn,              // Reset, active low
  input wire logic hreadyout,            // Slave ready
  input wire logic hresp,                // Response
  input wire logic supply_ok_in,         // Supply good
  input wire logic por_ok_in,            // Above power-on level
  input wire logic cap_charge_out,       // Capacitor charge
  input wire logic cap_discharge_out,    // Capacitor discharge
  input wire logic reset_out_n,          // System reset, active low
  input wire logic watchdog_fault_out_n  // Fault, active low
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  // Zero-wait OKAY slave
  bus_okay_a: assert property (hreadyout && !hresp)
    else $error("bus answer not ready or not okay");
  // Reset follows the supply
  uv_reset_a: assert property (!supply_ok_in [*8] |-> !reset_out_n)
    else $error("reset not asserted on low supply");
  por_reset_a: assert property (!por_ok_in [*8] |-> !reset_out_n)
    else $error("reset not asserted below power-on level");
  release_cause_a: assert property (
    $rose(reset_out_n) |-> $past(supply_ok_in, 4) && $past(por_ok_in, 4))
    else $error("reset released without good supply");
  // Supervisor reset overrides the watchdog
  fault_clear_a: assert property (!reset_out_n [*3] |-> watchdog_fault_out_n)
    else $error("fault held during reset");
  fault_gate_a: assert property ($fell(watchdog_fault_out_n) |-> reset_out_n)
    else $error("fault raised during reset");
  fault_width_a: assert property (
    $fell(watchdog_fault_out_n) |=> (!watchdog_fault_out_n || !reset_out_n) [*3])
    else $error("fault pulse too short");
  cap_excl_a: assert property (!(cap_charge_out && cap_discharge_out))
    else $error("charge and discharge together");
endmodule

bind supervised_timeout_watchdog watchdog_props u_watchdog_props (
  .hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp),
  .supply_ok_in(supply_ok_in), .por_ok_in(por_ok_in), .cap_charge_out(cap_charge_out),
  .cap_discharge_out(cap_discharge_out), .reset_out_n(reset_out_n),
  .watchdog_fault_out_n(watchdog_fault_out_n));

/* host_kick.sv */
`timescale 1ns/1ps
module host_kick (
  input  wire logic       clk,   // Host clock
  input  wire logic       rst_n, // Host reset, active low
  input  wire logic       run,   // Service the watchdog
  input  wire logic [7:0] gap,   // Cycles between kicks
  output logic            kick   // Kick line, falling edge counts
);
  logic [7:0] cnt_q;

  // Pulse low six cycles per interval; stopping restarts the interval
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 8'h00;
      kick  <= 1'b1;
    end else begin
      cnt_q <= (!run || cnt_q >= gap) ? 8'h00 : cnt_q + 8'h01;
      kick  <= !(run && cnt_q < 8'h06);
    end
  end
endmodule

/* tb.sv */
`timescale 1ns/1ps
`include "watchdog_defines.svh"
module tb;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic        supply_ok, por_ok, run, kick, rst_n, fault_n;
  logic        en_pin, cap_sense, dly_open, cap_chg;
  logic [1:0]  htrans, sel;
  logic [2:0]  hsize;
  logic [7:0]  haddr, gap;
  logic [31:0] hwdata, hrdata, rd;
  int          n_mismatch, comparisons, n;

  // Shortened timing so every frame fits the run
  localparam int TICK = 2, PWR_UP = 5, DLY_OPEN = 8, GRACE_CAP = 20;
  localparam int TO_MIN = 4, TO_MAX = 1000, DISCH = 2, CAP_LIM = 50;

  supervised_timeout_watchdog #(.TICK_CYCLES(TICK), .POWER_UP_TICKS(PWR_UP),
    .DELAY_OPEN_TICKS(DLY_OPEN), .GRACE_CAP_TICKS(GRACE_CAP), .TIMEOUT_MIN(TO_MIN),
    .TIMEOUT_MAX(TO_MAX), .DISCHARGE_TICKS(DISCH), .CAP_LIMIT(CAP_LIM))
    u_supervised_timeout_watchdog (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .supply_ok_in(supply_ok), .por_ok_in(por_ok),
    .watchdog_kick_in(kick), .watchdog_enable_pin(en_pin), .scale_select_low(sel[0]),
    .scale_select_high(sel[1]), .cap_sense_in(cap_sense), .delay_cap_open_in(dly_open),
    .cap_charge_out(cap_chg), .cap_discharge_out(), .reset_out_n(rst_n),
    .watchdog_fault_out_n(fault_n));
  host_kick u_host_kick (.clk(hclk), .rst_n(hresetn), .run(run), .gap(gap), .kick(kick));

  // 100 MHz clock
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  // Verdict and end of run
  task automatic test_done;
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // Compare and report
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Condition probed by waits
  function automatic logic probe(input int s);
    case (s)
      0: return !fault_n;
      1: return fault_n;
      2: return !rst_n;
      3: return rst_n;
      4: return cap_chg;
      default: return hreadyout;
    endcase
  endfunction

  // Bounded wait, counting edges
  task automatic waitfor(input int s, input int lim, output int cnt);
    cnt = 0;
    while (probe(s) !== 1'b1) begin
      cnt++;
      if (cnt > lim) begin
        chk("wait bound", 32'(s), 32'hff);
        test_done;
      end
      @(posedge hclk);
    end
  endtask

  // One AHB-Lite single word transfer; read data lands in rd
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= wr;
    repeat (2) begin
      @(posedge hclk);
      waitfor(5, 50, i);
      rd = hrdata;
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
    end
  endtask

  // No fault for a number of cycles
  task automatic quiet(input string nm, input int cyc);
    int lows;
    lows = 0;
    repeat (cyc) begin
      @(posedge hclk);
      if (fault_n !== 1'b1) lows++;
    end
    chk(nm, lows, 0);
  endtask

  // Fault arrives inside a window, then lasts the assert delay
  task automatic fault_at(input string nm, input int lo, input int hi);
    waitfor(0, 80, n);
    chk(nm, 32'(n >= lo && n <= hi), 1);
    waitfor(1, 40, n);
    chk("fault width", 32'(n >= 7 && n <= 12), 1);
  endtask

  // Reset values, unmapped place, configuration
  task automatic s_regs;
    logic [7:0]  ofs [5] = '{`OFS_CTRL, `OFS_TIMEOUT, `OFS_GRACE, `OFS_DELAY, `OFS_CAP_SCALE};
    logic [31:0] rv [5] = '{`RST_CTRL, `RST_TIMEOUT, `RST_GRACE, `RST_DELAY, `RST_CAP_SCALE};
    logic [31:0] cfg [5] = '{0, 20, 10, 4, `RST_CAP_SCALE};
    for (int i = 0; i < 5; i++) begin
      bus(1'b0, ofs[i], 0);
      chk("reset value", rd, rv[i]);
      bus(1'b1, ofs[i], cfg[i]);
      bus(1'b0, ofs[i], 0);
      chk("read back", rd, cfg[i]);
    end
    bus(1'b1, 8'h18, 32'hffff_ffff);
    bus(1'b0, 8'h18, 0);
    chk("unmapped", rd, 0);
  endtask

  // Enable pin control, select change out of grace, open delay capacitor
  task automatic s_enable_pin;
    bus(1'b1, `OFS_CTRL, 32'h4);
    en_pin <= 1'b0;
    quiet("pin off", 100);
    en_pin <= 1'b1;
    sel <= 2'b01;
    fault_at("pin frame", 36, 56);
    sel <= 2'b00;
    fault_at("select ends grace", 40, 56);
    bus(1'b1, `OFS_CTRL, 32'hc);
    waitfor(0, 80, n);
    waitfor(1, 40, n);
    chk("open delay width", 32'(n >= 15 && n <= 20), 1);
  endtask

  // Grounded timeout capacitor: one measurement after recovery, then watchdog off
  task automatic s_bad_cap;
    bus(1'b1, `OFS_CTRL, 32'h1);
    supply_ok <= 1'b0;
    waitfor(2, 12, n);
    supply_ok <= 1'b1;
    waitfor(4, 60, n);
    chk("measure start", 32'(n >= 12 && n <= 22), 1);
    quiet("bad cap", 200);
    bus(1'b0, `OFS_STATUS, 0);
    chk("cap status", rd, {16'(CAP_LIM), 16'h016c});
  endtask

  // Main sequence
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    htrans = 2'b00;
    haddr = 8'h00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0;
    supply_ok = 1'b0;
    por_ok = 1'b0;
    run = 1'b0;
    gap = 8'h14;
    sel = 2'b00;
    en_pin = 1'b1;
    cap_sense = 1'b0;
    dly_open = 1'b1;
    n_mismatch = 0;
    comparisons = 0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    s_regs;
    supply_ok <= 1'b1;
    por_ok <= 1'b1;
    waitfor(3, 60, n);
    chk("power-up hold", 32'(n >= 18 && n <= 30), 1);
    fault_at("grace expiry", 16, 30);
    fault_at("grace after fault", 16, 30);
    run <= 1'b1;
    quiet("kicked", 300);
    run <= 1'b0;
    gap <= 8'hfa;
    @(posedge hclk);
    run <= 1'b1;
    fault_at("missed kick", 40, 56);
    run <= 1'b0;
    sel <= 2'b01;
    quiet("select off", 200);
    sel <= 2'b00;
    fault_at("enable frame", 36, 56);
    bus(1'b1, `OFS_DELAY, 32'h10); // Long fault, so only the supply reset can end it early
    waitfor(0, 80, n);
    repeat (4) @(posedge hclk);
    supply_ok <= 1'b0;
    waitfor(2, 12, n);
    repeat (3) @(posedge hclk);
    chk("fault cleared", fault_n, 1);
    bus(1'b1, `OFS_DELAY, 32'h4);
    repeat (20) @(posedge hclk);
    supply_ok <= 1'b1;
    waitfor(3, 40, n);
    chk("uv release", 32'(n >= 8 && n <= 18), 1);
    fault_at("grace after reset", 16, 30);
    bus(1'b1, `OFS_CTRL, 32'h2);
    waitfor(2, 80, n);
    chk("fault pin idle", fault_n, 1);
    waitfor(3, 40, n);
    chk("combined width", 32'(n >= 7 && n <= 12), 1);
    s_enable_pin;
    s_bad_cap;
    test_done;
  end
endmodule
